// File: common/slcfg_pkg.sv
// Summary of operation
// - Pattern select zero sends normal sample data, and zero is its reset value.
// - Pattern code 8 repeats the lane alignment sequence and code 9 sends modified RPAT.
// - Pattern codes 10 and 11 hold the serial outputs low; codes 12 to 15 are reserved.
// - The eight-bit identifier goes out in the second multiframe of the alignment sequence.
// - Link A sends the identifier and link B sends the identifier plus one.
// - The identifier's lowest bit is ignored and reads back as zero.
// - End-of-frame select 0, 1, 2 picks K28.7, K28.1, K28.5; code 3 is reserved.
// - The end-of-frame character replaces a frame's last octet only when conditions allow.
// - With the link disabled, counters stay in reset and serializers are off and gated.
package slcfg_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // bus and register map
   localparam int AXI_AW = 12;
   localparam logic [9:0] IDX_LINK_CTRL = 10'h200;
   localparam logic [9:0] IDX_TEST_PAT = 10'h205;
   localparam logic [9:0] IDX_DEV_ID = 10'h206;
   localparam logic [9:0] IDX_FRAME_CHAR = 10'h207;
   localparam logic [9:0] IDX_LINK_STAT = 10'h20F;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // reset values and field positions
   localparam logic [7:0] RST_TEST_PAT = 8'h00;
   localparam logic [7:0] RST_DEV_ID = 8'h00;
   localparam logic [7:0] RST_FRAME_CHAR = 8'h00;
   localparam logic RST_LINK_EN = 1'h0;
   localparam int CTRL_EN_BIT = 0;
   localparam logic [7:0] DID_KEEP_MASK = 8'hFE;
   localparam int STAT_STATE_LSB = 1;
   localparam int STAT_LEVEL_LSB = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // pattern and end-of-frame codes
   localparam logic [3:0] TP_NORMAL = 4'h0;
   localparam logic [3:0] TP_PRBS7 = 4'h1;
   localparam logic [3:0] TP_PRBS15 = 4'h2;
   localparam logic [3:0] TP_PRBS23 = 4'h3;
   localparam logic [3:0] TP_RAMP = 4'h4;
   localparam logic [3:0] TP_TRANSPORT = 4'h5;
   localparam logic [3:0] TP_D21_5 = 4'h6;
   localparam logic [3:0] TP_K28_5 = 4'h7;
   localparam logic [3:0] TP_REP_ILA = 4'h8;
   localparam logic [3:0] TP_RPAT = 4'h9;
   localparam logic [3:0] TP_LOW_A = 4'hA;
   localparam logic [3:0] TP_LOW_B = 4'hB;
   localparam logic [1:0] FC_K28_7 = 2'h0;
   localparam logic [1:0] FC_K28_1 = 2'h1;
   localparam logic [1:0] FC_K28_5 = 2'h2;

   // 8b/10b character values before encoding
   localparam logic [7:0] CH_K28_0 = 8'h1C;
   localparam logic [7:0] CH_K28_1 = 8'h3C;
   localparam logic [7:0] CH_K28_3 = 8'h7C;
   localparam logic [7:0] CH_K28_4 = 8'h9C;
   localparam logic [7:0] CH_K28_5 = 8'hBC;
   localparam logic [7:0] CH_K28_7 = 8'hFC;
   localparam logic [7:0] CH_D21_5 = 8'hB5;

   // repeating data sequence of the modified random pattern
   localparam int RPAT_LEN = 4;
   localparam logic [7:0] RPAT_TAB [RPAT_LEN] = '{8'hBE, 8'hD7, 8'h23, 8'h47};

   // alignment sequence shape
   localparam logic [1:0] ILA_MF_LAST = 2'h3;
   localparam logic [1:0] ILA_MF_ID = 2'h1;
   localparam int ILA_OCT_Q = 1;
   localparam int ILA_OCT_ID = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_ILA = 3'b010,
      ST_RUN = 3'b100
   } slcfg_state_t;

   typedef struct packed {
      logic k;
      logic [7:0] d;
   } slcfg_sym_t;

endpackage

// File: rtl/slcfg_fifo.sv
`timescale 1ns/1ps
module slcfg_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   logic push;
   logic pop;

   // full when pointers differ only in the wrap bit
   assign level = wp_r - rp_r;
   assign in_ready = (level != (AW+1)'(DEPTH));
   assign out_valid = (wp_r != rp_r);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_r[rp_r[AW-1:0]];

   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r[AW-1:0]] <= in_data;
      end
   end

   // pointers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end
endmodule

// File: rtl/slcfg_prbs.sv
`timescale 1ns/1ps
module slcfg_prbs #(
   parameter int ORDER = 7,
   parameter int TAP = 6
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic clr,
   output logic [7:0] byte_r
);
   logic [ORDER-1:0] sh_r;
   logic [ORDER-1:0] sh_nxt;
   logic [7:0] byte_nxt;
   logic fb;

   // eight steps of x^ORDER + x^TAP + 1 per clock, first bit in msb
   always_comb begin
      sh_nxt = sh_r;
      byte_nxt = '0;
      fb = 1'b0;
      for (int b = 7; b >= 0; b--) begin
         fb = sh_nxt[ORDER-1] ^ sh_nxt[TAP-1];
         sh_nxt = {sh_nxt[ORDER-2:0], fb};
         byte_nxt[b] = fb;
      end
   end

   // seed all ones while cleared
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sh_r <= '1;
         byte_r <= '0;
      end else if (clr) begin
         sh_r <= '1;
         byte_r <= '0;
      end else begin
         sh_r <= sh_nxt;
         byte_r <= byte_nxt;
      end
   end
endmodule

// File: rtl/slcfg_top.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module slcfg_top #(
   parameter int FRAME_OCTETS = 2,
   parameter int FRAMES_PER_MF = 32,
   parameter int FIFO_DEPTH = 8,
   parameter int NUM_LINKS = 2
) (
   input wire logic clk,
   input wire logic nrst,
   // axi4-lite slave
   input wire logic [slcfg_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [slcfg_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // sample stream, one octet per link per word
   input wire logic [8*NUM_LINKS-1:0] smp_data,
   input wire logic smp_valid,
   output logic smp_ready,
   // lane symbols and serializer control
   output slcfg_pkg::slcfg_sym_t lane_sym_r [NUM_LINKS],
   output logic lane_hold_low_r,
   output logic ser_pwrdn_r,
   output logic ser_clk_en_r,
   output logic lmfc_rst_r
);
   import slcfg_pkg::*;

   localparam int MF_OCT = FRAME_OCTETS * FRAMES_PER_MF;
   localparam int OW = $clog2(MF_OCT);
   localparam int FW = (FRAME_OCTETS > 1) ? $clog2(FRAME_OCTETS) : 1;
   localparam int LW = $clog2(FIFO_DEPTH) + 1;
   localparam int RW = $clog2(RPAT_LEN);

   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   logic link_en_r;
   logic [7:0] test_pat_r;
   logic [7:0] dev_id_r;
   logic [7:0] frame_char_r;
   logic aw_got_r;
   logic w_got_r;
   logic [9:0] wr_idx_r;
   logic [31:0] wr_data_r;
   logic wr_lane0_r;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic wr_hit;
   slcfg_state_t state_r;
   slcfg_state_t state_nxt;
   logic [OW-1:0] oct_r;
   logic [FW-1:0] fr_r;
   logic [1:0] mf_r;
   logic [7:0] ramp_r;
   logic [RW-1:0] rpat_r;
   logic [7:0] prev_last_r [NUM_LINKS];
   logic [3:0] tp_eff;
   logic [7:0] eof_char;
   logic oct_last;
   logic fr_last;
   logic pat_normal;
   logic [8*NUM_LINKS-1:0] fifo_data;
   logic fifo_valid;
   logic fifo_pop;
   logic [LW-1:0] fifo_level;
   logic [7:0] prbs_byte [3];
   slcfg_sym_t sym_nxt [NUM_LINKS];
   slcfg_sym_t ila_sym [NUM_LINKS];
   logic [7:0] smp_byte [NUM_LINKS];

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite write path: address and data taken in either order
   assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
   assign s_axi_wready = !w_got_r && !s_axi_bvalid;
   assign wr_hit = (wr_idx_r == IDX_LINK_CTRL) || (wr_idx_r == IDX_TEST_PAT) ||
                   (wr_idx_r == IDX_DEV_ID) || (wr_idx_r == IDX_FRAME_CHAR);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         wr_idx_r <= '0;
         wr_data_r <= '0;
         wr_lane0_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            wr_idx_r <= s_axi_awaddr[AXI_AW-1:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wr_data_r <= s_axi_wdata;
            wr_lane0_r <= s_axi_wstrb[0];
         end
         if (aw_got_r && w_got_r && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // register stores, low byte lane only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         link_en_r <= RST_LINK_EN;
         test_pat_r <= RST_TEST_PAT;
         dev_id_r <= RST_DEV_ID;
         frame_char_r <= RST_FRAME_CHAR;
      end else if (aw_got_r && w_got_r && !s_axi_bvalid && wr_lane0_r) begin
         // settings are expected to change only with the link disabled
         unique case (wr_idx_r)
            IDX_LINK_CTRL: link_en_r <= wr_data_r[CTRL_EN_BIT];
            IDX_TEST_PAT: test_pat_r <= wr_data_r[7:0];
            IDX_DEV_ID: dev_id_r <= wr_data_r[7:0] & DID_KEEP_MASK;
            IDX_FRAME_CHAR: frame_char_r <= wr_data_r[7:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite read path
   always_comb begin
      rd_mux = '0;
      rd_hit = 1'b1;
      unique case (s_axi_araddr[AXI_AW-1:2])
         IDX_LINK_CTRL: rd_mux[CTRL_EN_BIT] = link_en_r;
         IDX_TEST_PAT: rd_mux[7:0] = test_pat_r;
         IDX_DEV_ID: rd_mux[7:0] = dev_id_r;
         IDX_FRAME_CHAR: rd_mux[7:0] = frame_char_r;
         IDX_LINK_STAT: begin
            rd_mux[STAT_STATE_LSB +: 3] = state_r;
            rd_mux[STAT_LEVEL_LSB +: LW] = fifo_level;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // setting decode
   // reserved codes fall back to zero
   assign tp_eff = (test_pat_r[3:0] > TP_LOW_B) ? TP_NORMAL : test_pat_r[3:0];
   assign pat_normal = (tp_eff == TP_NORMAL);

   always_comb begin
      unique case (frame_char_r[1:0])
         FC_K28_1: eof_char = CH_K28_1;
         FC_K28_5: eof_char = CH_K28_5;
         default: eof_char = CH_K28_7;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // link sequencing
   assign oct_last = (oct_r == OW'(MF_OCT - 1));
   assign fr_last = (fr_r == FW'(FRAME_OCTETS - 1));

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_OFF: if (link_en_r) state_nxt = pat_normal ? ST_ILA : ST_RUN;
         ST_ILA: if (oct_last && mf_r == ILA_MF_LAST) state_nxt = ST_RUN;
         ST_RUN: ;
      endcase
      if (!link_en_r) begin
         state_nxt = ST_OFF;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= ST_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   // frame and multiframe counters cleared while disabled
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         oct_r <= '0;
         fr_r <= '0;
         mf_r <= '0;
         ramp_r <= '0;
         rpat_r <= '0;
      end else if (state_r == ST_OFF) begin
         oct_r <= '0;
         fr_r <= '0;
         mf_r <= '0;
         ramp_r <= '0;
         rpat_r <= '0;
      end else begin
         oct_r <= oct_last ? '0 : oct_r + 1'b1;
         fr_r <= fr_last ? '0 : fr_r + 1'b1;
         if (oct_last) begin
            mf_r <= mf_r + 1'b1;
         end
         ramp_r <= ramp_r + 1'b1;
         rpat_r <= (rpat_r == RW'(RPAT_LEN - 1)) ? '0 : rpat_r + 1'b1;
      end
   end

   // serializers off and clock gated while disabled
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ser_pwrdn_r <= 1'b1;
         ser_clk_en_r <= 1'b0;
         lmfc_rst_r <= 1'b1;
         lane_hold_low_r <= 1'b0;
      end else begin
         ser_pwrdn_r <= !link_en_r;
         ser_clk_en_r <= link_en_r;
         lmfc_rst_r <= !link_en_r;
         lane_hold_low_r <= link_en_r && (tp_eff == TP_LOW_A || tp_eff == TP_LOW_B);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sample buffer, drained only while normal data is sent
   assign fifo_pop = (state_r == ST_RUN) && pat_normal;

   slcfg_fifo #(.WIDTH(8 * NUM_LINKS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_data(smp_data),
      .in_valid(smp_valid),
      .in_ready(smp_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .level(fifo_level)
   );

   // pseudo-random generators of order 7, 15, 23
   slcfg_prbs #(.ORDER(7), .TAP(6)) u_prbs7 (
      .clk(clk), .nrst(nrst), .clr(state_r == ST_OFF), .byte_r(prbs_byte[0]));
   slcfg_prbs #(.ORDER(15), .TAP(14)) u_prbs15 (
      .clk(clk), .nrst(nrst), .clr(state_r == ST_OFF), .byte_r(prbs_byte[1]));
   slcfg_prbs #(.ORDER(23), .TAP(18)) u_prbs23 (
      .clk(clk), .nrst(nrst), .clr(state_r == ST_OFF), .byte_r(prbs_byte[2]));

   ////////////////////////////////////////////////////////////////////////////////
   // per-lane symbol selection
   always_comb begin
      for (int i = 0; i < NUM_LINKS; i++) begin
         smp_byte[i] = fifo_valid ? fifo_data[8*i +: 8] : 8'h00;
         // alignment sequence: R at start, A at end, Q then identifier in mf 1
         ila_sym[i] = '{k: 1'b0, d: 8'(oct_r)};
         if (oct_r == '0) begin
            ila_sym[i] = '{k: 1'b1, d: CH_K28_0};
         end else if (oct_last) begin
            ila_sym[i] = '{k: 1'b1, d: CH_K28_3};
         end else if (mf_r == ILA_MF_ID && oct_r == OW'(ILA_OCT_Q)) begin
            ila_sym[i] = '{k: 1'b1, d: CH_K28_4};
         end else if (mf_r == ILA_MF_ID && oct_r == OW'(ILA_OCT_ID)) begin
            ila_sym[i] = '{k: 1'b0, d: dev_id_r + 8'(i)};
         end
         sym_nxt[i] = '{k: 1'b0, d: 8'h00};
         if (state_r == ST_ILA) begin
            sym_nxt[i] = ila_sym[i];
         end else if (state_r == ST_RUN) begin
            unique case (tp_eff)
               TP_PRBS7: sym_nxt[i].d = prbs_byte[0];
               TP_PRBS15: sym_nxt[i].d = prbs_byte[1];
               TP_PRBS23: sym_nxt[i].d = prbs_byte[2];
               TP_RAMP: sym_nxt[i].d = ramp_r;
               TP_TRANSPORT: sym_nxt[i].d = {1'b0, 1'(i), 6'(oct_r)};
               TP_D21_5: sym_nxt[i].d = CH_D21_5;
               TP_K28_5: sym_nxt[i] = '{k: 1'b1, d: CH_K28_5};
               // repeated alignment and modified random pattern
               TP_REP_ILA: sym_nxt[i] = ila_sym[i];
               TP_RPAT: sym_nxt[i].d = RPAT_TAB[rpat_r];
               TP_LOW_A, TP_LOW_B: sym_nxt[i] = '{k: 1'b0, d: 8'h00};
               default: begin
                  sym_nxt[i].d = smp_byte[i];
                  // substitute only when the frame end repeats
                  if (fr_last && smp_byte[i] == prev_last_r[i]) begin
                     sym_nxt[i] = '{k: 1'b1, d: eof_char};
                  end
               end
            endcase
         end
      end
   end

   // lane output and last-octet history
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_LINKS; i++) begin
            lane_sym_r[i] <= '0;
            prev_last_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_LINKS; i++) begin
            lane_sym_r[i] <= sym_nxt[i];
            if (state_r != ST_RUN) begin
               prev_last_r[i] <= '0;
            end else if (fr_last) begin
               prev_last_r[i] <= smp_byte[i];
            end
         end
      end
   end
endmodule

// File: verification/slcfg_top_props.sv
`timescale 1ns/1ps
module slcfg_top_props #(
   parameter int NUM_LINKS = 2
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire slcfg_pkg::slcfg_sym_t lane_sym_r [NUM_LINKS],
   input wire logic lane_hold_low_r,
   input wire logic ser_pwrdn_r,
   input wire logic ser_clk_en_r,
   input wire logic lmfc_rst_r
);
   import slcfg_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////////////
   // serializer control while disabled
   a_clk_gated: assert property (ser_clk_en_r == !ser_pwrdn_r)
      else $error("serializer clock enable not inverse of power down");
   a_lmfc_held: assert property (lmfc_rst_r == ser_pwrdn_r)
      else $error("multiframe counter reset not tied to disable");
   a_hold_enabled: assert property (lane_hold_low_r |-> !ser_pwrdn_r)
      else $error("outputs held low while link disabled");
   a_hold_zero: assert property (lane_hold_low_r |=> !lane_hold_low_r || lane_sym_r[0] == 9'h000)
      else $error("held lane carries nonzero symbol");
   // identifier octet follows the lane marker
   a_did_plus_one: assert property (lane_sym_r[0] == {1'b1, CH_K28_4} |=>
      lane_sym_r[1].d == lane_sym_r[0].d + 8'h01) else $error("link B identifier not A plus one");
   a_did_even: assert property (lane_sym_r[0] == {1'b1, CH_K28_4} |=>
      !lane_sym_r[0].k && !lane_sym_r[0].d[0]) else $error("identifier octet odd or control");
   ////////////////////////////////////////////////////////////////////////////////
   // register bus answers
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
   a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##1 1'b1)
      else $error("read data late");
   a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read data not released");
   c_hold: cover property (lane_hold_low_r);
   c_marker: cover property (lane_sym_r[0] == {1'b1, CH_K28_4});
   c_enable: cover property ($fell(ser_pwrdn_r));
endmodule
bind slcfg_top slcfg_top_props #(.NUM_LINKS(NUM_LINKS)) i_slcfg_top_props (.clk(clk), .nrst(nrst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .lane_sym_r(lane_sym_r), .lane_hold_low_r(lane_hold_low_r),
   .ser_pwrdn_r(ser_pwrdn_r), .ser_clk_en_r(ser_clk_en_r), .lmfc_rst_r(lmfc_rst_r));

// File: verification/slcfg_lane_rx.sv
`timescale 1ns/1ps
module slcfg_lane_rx (
   input wire logic clk,
   input wire logic nrst,
   input wire slcfg_pkg::slcfg_sym_t lane_sym [2],
   output logic [7:0] k_cnt
);
   import slcfg_pkg::*;
   // counts control characters on link A; every control character adds one, not only the end characters
   // plain receiver accepts chosen comma
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         k_cnt <= 8'h00;
      end else if (lane_sym[0].k) begin
         k_cnt <= k_cnt + 8'h01;
      end
   end
endmodule

// File: verification/tb_slcfg_top.sv
`timescale 1ns/1ps
module tb_slcfg_top;
   import slcfg_pkg::*;
   logic clk = 1'b0, nrst = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [15:0] smp_data = 16'h0000;
   logic smp_valid = 1'b0, smp_ready, lane_hold_low_r, ser_pwrdn_r, ser_clk_en_r, lmfc_rst_r;
   slcfg_sym_t lane_sym_r [2];
   logic [7:0] k_cnt, a, b;
   logic [31:0] rv;
   int errors = 0, check_count = 0, cyc = 0, n;
   always #2 clk = ~clk;
   slcfg_top i_slcfg_top (.clk(clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .smp_data(smp_data), .smp_valid(smp_valid), .smp_ready(smp_ready), .lane_sym_r(lane_sym_r),
      .lane_hold_low_r(lane_hold_low_r), .ser_pwrdn_r(ser_pwrdn_r), .ser_clk_en_r(ser_clk_en_r),
      .lmfc_rst_r(lmfc_rst_r));
   slcfg_lane_rx i_slcfg_lane_rx (.clk(clk), .nrst(nrst), .lane_sym(lane_sym_r), .k_cnt(k_cnt));
   ////////////////////////////////////////////////////////////////////////////////
   // verdict and shared helpers
   task wrap_up;
      $display("errors=%0d check_count=%0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task chk(input logic c, input string m);
      check_count++;
      if (c !== 1'b1) begin
         errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task wr(input logic [11:0] ad, input logic [7:0] d);
      @(posedge clk);
      s_axi_awaddr <= ad;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h0, d};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            rsp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask
   task rd(input logic [11:0] ad);
      @(posedge clk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            rv = s_axi_rdata;
            rsp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask
   // settings change only with the link off, then the link is switched on
   task en(input logic [7:0] p);
      wr(12'h800, 8'h00);
      wr(12'h814, p);
      wr(12'h800, 8'h01);
   endtask
   task wsym(input int ln, input logic [8:0] s, input string m);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (lane_sym_r[ln] !== s && n < 400);
      chk(lane_sym_r[ln] === s, m);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task t_reset;
      rd(12'h814); chk(rv === 32'h0 && rsp === RESP_OKAY, "pattern reset");
      rd(12'h818); chk(rv === 32'h0, "identifier reset");
      rd(12'h81C); chk(rv === 32'h0, "end char reset");
      rd(12'hFFC); chk(rsp === RESP_SLVERR, "unmapped read");
      wr(12'hFFC, 8'h01);
      chk(rsp === RESP_SLVERR, "unmapped write");
      chk(ser_pwrdn_r === 1'b1 && lmfc_rst_r === 1'b1, "disabled outputs");
   endtask
   task t_ila;
      wr(12'h818, 8'h57);
      chk(rsp === RESP_OKAY, "write okay");
      rd(12'h818); chk(rv === 32'h56, "identifier lsb");
      // sample octets chosen outside the alignment octet indices
      smp_data <= 16'hA5C3;
      smp_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (smp_valid && smp_ready) n++;
      end while (smp_ready !== 1'b0 && n < 20);
      smp_valid <= 1'b0;
      chk(n == 8, "fifo depth");
      en(8'h00);
      wsym(0, {1'b1, CH_K28_4}, "lane marker");
      @(posedge clk);
      chk(lane_sym_r[0] === 9'h056, "link A identifier");
      chk(lane_sym_r[1] === 9'h057, "link B identifier");
      wsym(0, 9'h0C3, "sample data");
      chk(lane_sym_r[1] === 9'h0A5, "link B sample");
      repeat (12) @(posedge clk);
      chk(smp_ready === 1'b1, "fifo drained");
   endtask
   task t_pat;
      logic [3:0] pc [7];
      logic [8:0] ps [7];
      pc = '{4'h6, 4'h7, 4'h9, 4'h8, 4'hC, 4'hA, 4'hB};
      ps = '{9'h0B5, 9'h1BC, 9'h0BE, 9'h19C, 9'h11C, 9'h000, 9'h000};
      for (int i = 0; i < 7; i++) begin
         en({4'h0, pc[i]});
         wsym(0, ps[i], "pattern symbol");
         repeat (3) @(posedge clk);
         chk(lane_hold_low_r === (pc[i] == 4'hA || pc[i] == 4'hB), "hold low");
      end
      for (int i = 1; i < 6; i++) begin
         en(i[7:0]);
         repeat (4) @(posedge clk);
         a = lane_sym_r[0].d;
         @(posedge clk);
         b = lane_sym_r[0].d;
         if (i == 4) chk(b === a + 8'h01, "ramp step");
         if (i == 5) chk(lane_sym_r[1].d[7:6] === 2'b01, "transport link");
         if (i < 4) chk(a !== b && lane_sym_r[0].k === 1'b0, "prbs moves");
      end
   endtask
   task t_fc;
      logic [7:0] ec [4];
      ec = '{CH_K28_7, CH_K28_1, CH_K28_5, CH_K28_7};
      for (int f = 0; f < 4; f++) begin
         wr(12'h800, 8'h00);
         wr(12'h81C, f[7:0]);
         en(8'h00);
         a = k_cnt;
         wsym(0, {1'b1, ec[f]}, "end char");
      end
      chk(k_cnt !== a, "receiver saw commas");
      wr(12'h800, 8'h00);
      repeat (3) @(posedge clk);
      chk(ser_pwrdn_r === 1'b1 && ser_clk_en_r === 1'b0, "power down");
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         errors++;
         wrap_up;
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_reset;
      t_ila;
      t_pat;
      t_fc;
      wrap_up;
   end
endmodule
